// ### verilog/csp_supervisor.sv
// charger supervisor: processor-hot, watchdog, calibration, overcurrent, converter
`timescale 1ns/1ps
`default_nettype none
module csp_supervisor #(
	parameter int DG_W = 24,
	parameter int HOT_W0_CYC = csp_pkg::HOT_W0_MS * csp_pkg::MS_CYC,
	parameter int HOT_W1_CYC = csp_pkg::HOT_W1_MS * csp_pkg::MS_CYC,
	parameter int HOT_W2_CYC = csp_pkg::HOT_W2_MS * csp_pkg::MS_CYC,
	parameter int HOT_W3_CYC = csp_pkg::HOT_W3_MS * csp_pkg::MS_CYC,
	parameter longint WDT_P1_CYC = longint'(csp_pkg::WDT_P1_S) * 1000 * csp_pkg::MS_CYC,
	parameter longint WDT_P2_CYC = longint'(csp_pkg::WDT_P2_S) * 1000 * csp_pkg::MS_CYC,
	parameter longint WDT_P3_CYC = longint'(csp_pkg::WDT_P3_S) * 1000 * csp_pkg::MS_CYC,
	parameter int OVC_CYC = csp_pkg::OVC_CYC,
	parameter int FREQ_DIV_600K = 167,
	parameter int FREQ_DIV_800K = 125,
	parameter int FREQ_DIV_1M = 100
) (
	// clock and reset (overcurrent latch also clears on detect release)
	input wire logic i_clk,
	input wire logic i_rst_b,
	// hot configuration
	input wire logic [6:0] i_hot_enable,
	input wire logic [1:0] i_hot_width,
	input wire logic [DG_W-1:0] i_dg_peak,
	input wire logic [DG_W-1:0] i_dg_avg,
	input wire logic [DG_W-1:0] i_dg_dchg,
	input wire logic [DG_W-1:0] i_dg_cmp,
	input wire logic i_status_clear,
	// level comparators against host thresholds
	input wire logic i_peak_over,
	input wire logic i_avg_over_110,
	input wire logic i_dchg_over,
	input wire logic i_system_voltage_event_under,
	input wire logic [2:0] i_cell_count,
	// pins
	input wire logic i_adapter_good,
	input wire logic i_battery_present_n,
	input wire logic i_comparator_output,
	input wire logic i_adapter_detect,
	// calibration
	input wire logic i_cal_set,
	input wire logic i_battery_depleted,
	// watchdog
	input wire logic [1:0] i_wdt_period,
	input wire logic i_charge_voltage_limit_wr,
	input wire logic i_charge_current_limit_wr,
	// overcurrent
	input wire logic i_ovc_2x,
	input wire logic i_ovc_disable,
	input wire logic i_in_over_125,
	input wire logic i_in_over_200,
	// converter
	input wire logic [1:0] i_freq_sel,
	input wire logic i_conv_enable,
	input wire logic i_ramp_above_eao,
	input wire logic i_undercurrent_comparator,
	input wire logic i_below_low_level,
	input wire logic i_above_high_level,
	// hot outputs
	output logic o_processor_hot_n,
	output logic [6:0] o_hot_status,
	// power path
	output logic o_battery_calibration_mode,
	output logic o_adapter_switch,
	output logic o_reverse_block_switch,
	output logic o_battery_switch,
	output logic o_input_overcurrent_latch,
	// watchdog and converter
	output logic o_wdt_expired,
	output logic o_cycle_start,
	output logic o_high_side_switch,
	output logic o_low_side_switch,
	output logic o_discontinuous_conduction
);
	initial begin
		if (DG_W < 2 || FREQ_DIV_1M < 8 || FREQ_DIV_600K > 256) $error("parameters out of range");
	end
	// edge history for pin triggers
	logic adg_d_r, bpn_d_r, cmp_d_r;
	logic [6:0] raw;
	logic [6:0] fired;
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			adg_d_r <= 1'b1;
			bpn_d_r <= 1'b0;
			cmp_d_r <= 1'b1;
		end else begin
			adg_d_r <= i_adapter_good;
			bpn_d_r <= i_battery_present_n;
			cmp_d_r <= i_comparator_output;
		end
	end
	// raw source levels; adapter, battery and comparator are single-cycle edges
	assign raw[csp_pkg::SRC_PEAK] = i_peak_over;
	assign raw[csp_pkg::SRC_AVG] = i_avg_over_110;
	assign raw[csp_pkg::SRC_DCHG] = i_dchg_over;
	assign raw[csp_pkg::SRC_SYSTEM_VOLTAGE_EVENT] = i_system_voltage_event_under && i_cell_count >= 3'h2 && i_cell_count <= 3'h4;
	assign raw[csp_pkg::SRC_ADPT] = adg_d_r && !i_adapter_good;
	assign raw[csp_pkg::SRC_BATT] = !bpn_d_r && i_battery_present_n;
	assign raw[csp_pkg::SRC_CMP] = cmp_d_r && !i_comparator_output;
	// peak, average and discharge deglitched with host lengths; voltage event, adapter and battery edges pass straight
	csp_deglitch #(.CW(DG_W)) u_dg_peak (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_raw(raw[csp_pkg::SRC_PEAK]), .i_len(i_dg_peak), .o_level(fired[csp_pkg::SRC_PEAK]));
	csp_deglitch #(.CW(DG_W)) u_dg_avg (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_raw(raw[csp_pkg::SRC_AVG]), .i_len(i_dg_avg), .o_level(fired[csp_pkg::SRC_AVG]));
	csp_deglitch #(.CW(DG_W)) u_dg_dchg (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_raw(raw[csp_pkg::SRC_DCHG]), .i_len(i_dg_dchg), .o_level(fired[csp_pkg::SRC_DCHG]));
	assign fired[csp_pkg::SRC_SYSTEM_VOLTAGE_EVENT] = raw[csp_pkg::SRC_SYSTEM_VOLTAGE_EVENT];
	assign fired[csp_pkg::SRC_ADPT] = raw[csp_pkg::SRC_ADPT];
	assign fired[csp_pkg::SRC_BATT] = raw[csp_pkg::SRC_BATT];
	// comparator edge is stretched into the filter so a length applies
	logic cmp_low_r;
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) cmp_low_r <= 1'b0;
		else cmp_low_r <= raw[csp_pkg::SRC_CMP] || (cmp_low_r && !i_comparator_output);
	end
	csp_deglitch #(.CW(DG_W)) u_dg_cmp (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_raw(cmp_low_r), .i_len(i_dg_cmp), .o_level(fired[csp_pkg::SRC_CMP]));
	// processor-hot pulse timer
	logic [6:0] hit;
	logic any_hit;
	logic [31:0] hot_cnt_r;
	logic [31:0] hot_len;
	assign hit = fired & i_hot_enable;
	assign any_hit = |hit;
	always_comb begin
		case (i_hot_width)
			2'h0: hot_len = 32'(HOT_W0_CYC);
			2'h1: hot_len = 32'(HOT_W1_CYC);
			2'h2: hot_len = 32'(HOT_W2_CYC);
			default: hot_len = 32'(HOT_W3_CYC);
		endcase
	end
	// low for minimum width, extended while a level event persists
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_processor_hot_n <= 1'b1;
			hot_cnt_r <= '0;
		end else if (o_processor_hot_n) begin
			if (any_hit) begin
				o_processor_hot_n <= 1'b0;
				hot_cnt_r <= 32'h1;
			end
		end else if (hot_cnt_r < hot_len) begin
			hot_cnt_r <= hot_cnt_r + 32'h1;
		end else if (!any_hit) begin
			o_processor_hot_n <= 1'b1;
		end
	end
	// status: enabled sources that fired; a new fire wins over a clear
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) o_hot_status <= '0;
		else o_hot_status <= (i_status_clear ? 7'h00 : o_hot_status) | hit;
	end
	// calibration mode and power path
	logic batt_rise;
	assign batt_rise = !bpn_d_r && i_battery_present_n;
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) o_battery_calibration_mode <= 1'b0;
		else if (batt_rise || i_battery_depleted) o_battery_calibration_mode <= 1'b0;
		else if (i_cal_set) o_battery_calibration_mode <= 1'b1;
	end
	// adapter path off in calibration or overcurrent latch
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_adapter_switch <= 1'b0;
			o_reverse_block_switch <= 1'b0;
			o_battery_switch <= 1'b1;
		end else begin
			o_adapter_switch <= !o_battery_calibration_mode && !o_input_overcurrent_latch
				&& i_adapter_good;
			o_reverse_block_switch <= !o_battery_calibration_mode && !o_input_overcurrent_latch
				&& i_adapter_good;
			o_battery_switch <= o_battery_calibration_mode || !i_adapter_good
				|| o_input_overcurrent_latch;
		end
	end
	// input overcurrent: held continuously for the blank time, then latch
	logic ovc_raw;
	logic [31:0] ovc_cnt_r;
	assign ovc_raw = !i_ovc_disable && (i_ovc_2x ? i_in_over_200 : i_in_over_125);
	always_ff @(posedge i_clk) begin
		if (!i_rst_b || !i_adapter_detect) begin
			ovc_cnt_r <= '0;
			o_input_overcurrent_latch <= 1'b0;
		end else if (!ovc_raw) begin
			ovc_cnt_r <= '0;
		end else if (ovc_cnt_r >= 32'(OVC_CYC - 1)) begin
			o_input_overcurrent_latch <= 1'b1;
		end else begin
			ovc_cnt_r <= ovc_cnt_r + 32'h1;
		end
	end
	// watchdog: refresh on limit write or period change
	logic [1:0] wdt_per_r;
	logic [39:0] wdt_cnt_r;
	logic [39:0] wdt_len;
	logic wdt_kick;
	assign wdt_kick = i_charge_voltage_limit_wr || i_charge_current_limit_wr
		|| (i_wdt_period != wdt_per_r);
	always_comb begin
		case (i_wdt_period)
			2'h1: wdt_len = 40'(WDT_P1_CYC);
			2'h2: wdt_len = 40'(WDT_P2_CYC);
			default: wdt_len = 40'(WDT_P3_CYC);
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			wdt_per_r <= csp_pkg::WDT_RST;
			wdt_cnt_r <= '0;
			o_wdt_expired <= 1'b0;
		end else begin
			wdt_per_r <= i_wdt_period;
			if (wdt_kick || i_wdt_period == csp_pkg::WDT_OFF) begin
				wdt_cnt_r <= '0;
				o_wdt_expired <= 1'b0;
			end else if (wdt_cnt_r >= wdt_len - 40'h1) begin
				o_wdt_expired <= 1'b1;
			end else begin
				wdt_cnt_r <= wdt_cnt_r + 40'h1;
			end
		end
	end
	// switching period from frequency field
	logic [7:0] per_r;
	logic [7:0] per_len;
	always_comb begin
		case (i_freq_sel)
			csp_pkg::FREQ_600K: per_len = 8'(FREQ_DIV_600K - 1);
			csp_pkg::FREQ_1M: per_len = 8'(FREQ_DIV_1M - 1);
			default: per_len = 8'(FREQ_DIV_800K - 1);
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			per_r <= '0;
			o_cycle_start <= 1'b0;
		end else begin
			o_cycle_start <= (per_r == 8'h00);
			per_r <= (per_r >= per_len) ? 8'h00 : per_r + 8'h01;
		end
	end
	// converter suspended on watchdog; settings untouched
	csp_pwm u_pwm (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_run(i_conv_enable && !o_wdt_expired && !o_input_overcurrent_latch),
		.i_cycle_start(o_cycle_start), .i_ramp_above_eao(i_ramp_above_eao),
		.i_undercurrent_comparator(i_undercurrent_comparator),
		.i_below_low_level(i_below_low_level), .i_above_high_level(i_above_high_level),
		.o_high_side_switch(o_high_side_switch), .o_low_side_switch(o_low_side_switch),
		.o_discontinuous_conduction(o_discontinuous_conduction));
	// checks
	chk_hot_assert: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_processor_hot_n && any_hit) |=> !o_processor_hot_n)
		else $error("hot not asserted on event");
	chk_hot_extend: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(!o_processor_hot_n && any_hit) |=> !o_processor_hot_n)
		else $error("hot released while event active");
	chk_hot_min: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$rose(o_processor_hot_n) |-> $past(hot_cnt_r) >= hot_len)
		else $error("hot pulse too short");
	chk_status_rec: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(hit != 7'h00) |=> ((o_hot_status & $past(hit)) == $past(hit)))
		else $error("fired source not recorded");
	chk_enable_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_processor_hot_n && fired != 7'h00 && (fired & i_hot_enable) == 7'h00)
		|=> o_processor_hot_n)
		else $error("disabled source counted");
	chk_cal_exit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_battery_calibration_mode && batt_rise && i_adapter_good
		&& !o_input_overcurrent_latch) |-> ##2 o_adapter_switch)
		else $error("adapter switch late on battery removal");
	chk_cal_path: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_battery_calibration_mode |=> (!o_adapter_switch && o_battery_switch))
		else $error("calibration path wrong");
	chk_ovc_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_input_overcurrent_latch && i_adapter_detect |=> o_input_overcurrent_latch)
		else $error("overcurrent latch lost");
	chk_wdt_resume: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_wdt_expired && i_charge_current_limit_wr) |=> !o_wdt_expired)
		else $error("watchdog not restarted");
	cov_hot_pulse: cover property (@(posedge i_clk) disable iff (!i_rst_b)
		$fell(o_processor_hot_n) ##[1:1000] $rose(o_processor_hot_n));
	cov_cal_cycle: cover property (@(posedge i_clk) disable iff (!i_rst_b)
		$fell(o_battery_calibration_mode));
	cov_wdt: cover property (@(posedge i_clk) disable iff (!i_rst_b) $rose(o_wdt_expired));
endmodule : csp_supervisor
`default_nettype wire

// ### verilog/csp_pkg.sv
// constants for the charger supervisor block
package csp_pkg;
	// clock and time units
	localparam int CLK_MHZ = 100;
	localparam int MS_CYC = CLK_MHZ * 1000;
	// processor-hot pulse width codes (ms)
	localparam int HOT_W0_MS = 5;
	localparam int HOT_W1_MS = 1;
	localparam int HOT_W2_MS = 10;
	localparam int HOT_W3_MS = 20;
	localparam logic [1:0] HOT_WIDTH_RST = 2'h2;
	localparam int HOT_SRC_N = 7;
	// source bit positions
	localparam int SRC_PEAK = 0;
	localparam int SRC_AVG = 1;
	localparam int SRC_DCHG = 2;
	localparam int SRC_SYSTEM_VOLTAGE_EVENT = 3;
	localparam int SRC_ADPT = 4;
	localparam int SRC_BATT = 5;
	localparam int SRC_CMP = 6;
	// watchdog periods (s) and field codes
	localparam int WDT_P1_S = 5;
	localparam int WDT_P2_S = 88;
	localparam int WDT_P3_S = 175;
	localparam logic [1:0] WDT_OFF = 2'h0;
	localparam logic [1:0] WDT_RST = 2'h3;
	// switching frequency field codes
	localparam logic [1:0] FREQ_600K = 2'h0;
	localparam logic [1:0] FREQ_800K = 2'h1;
	localparam logic [1:0] FREQ_1M = 2'h2;
	localparam logic [1:0] FREQ_RST = 2'h1;
	// input overcurrent blank time and calibration-exit bound
	localparam int OVC_MS = 12;
	localparam int OVC_CYC = OVC_MS * MS_CYC;
	localparam int BATT_EXIT_US = 100;
	localparam int BATT_EXIT_CYC = BATT_EXIT_US * CLK_MHZ;
	// converter dead time in cycles
	localparam int DEAD_CYC = 2;
	// states of the conduction sequencer
	typedef enum logic [1:0] {
		CSP_PH_IDLE = 2'b00,
		CSP_PH_HIGH = 2'b01,
		CSP_PH_DEAD = 2'b10,
		CSP_PH_LOW = 2'b11
	} csp_phase_t;
endpackage : csp_pkg

// ### verilog/csp_deglitch.sv
// cycle-counted deglitch filter for one event source
`timescale 1ns/1ps
`default_nettype none
module csp_deglitch #(
	parameter int CW = 24
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// raw level and programmed length
	input wire logic i_raw,
	input wire logic [CW-1:0] i_len,
	// filtered level
	output logic o_level
);
	logic [CW-1:0] cnt_r;
	initial begin
		if (CW < 2) $error("deglitch counter too narrow");
	end
	// level must persist i_len + 1 cycles before it counts
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			cnt_r <= '0;
			o_level <= 1'b0;
		end else if (!i_raw) begin
			cnt_r <= '0;
			o_level <= 1'b0;
		end else if (cnt_r >= i_len) begin
			o_level <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end
endmodule : csp_deglitch
`default_nettype wire

// ### verilog/csp_pwm.sv
// high/low side switch sequencer with dead time and light-load hysteresis
`timescale 1ns/1ps
`default_nettype none
module csp_pwm (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// cycle timing and comparators
	input wire logic i_run,
	input wire logic i_cycle_start,
	input wire logic i_ramp_above_eao,
	input wire logic i_undercurrent_comparator,
	input wire logic i_below_low_level,
	input wire logic i_above_high_level,
	// switch drives
	output logic o_high_side_switch,
	output logic o_low_side_switch,
	output logic o_discontinuous_conduction
);
	csp_pkg::csp_phase_t ph_r;
	logic [3:0] dead_r;
	logic dead_to_low_r;
	logic lowok_r;
	// light-load hysteresis: off below low level, back on above high level
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) lowok_r <= 1'b1;
		else if (i_below_low_level) lowok_r <= 1'b0;
		else if (i_above_high_level) lowok_r <= 1'b1;
	end
	// cycle: high until ramp passes error amp, dead, low, dead at cycle end
	always_ff @(posedge i_clk) begin
		if (!i_rst_b || !i_run) begin
			ph_r <= csp_pkg::CSP_PH_IDLE;
			dead_r <= '0;
			dead_to_low_r <= 1'b0;
			o_discontinuous_conduction <= 1'b0;
		end else begin
			case (ph_r)
				csp_pkg::CSP_PH_IDLE: begin
					if (i_cycle_start) ph_r <= csp_pkg::CSP_PH_HIGH;
				end
				csp_pkg::CSP_PH_HIGH: begin
					if (i_ramp_above_eao) begin
						ph_r <= csp_pkg::CSP_PH_DEAD;
						dead_r <= '0;
						dead_to_low_r <= 1'b1;
					end
				end
				csp_pkg::CSP_PH_DEAD: begin
					if (dead_r >= 4'(csp_pkg::DEAD_CYC - 1)) begin
						ph_r <= dead_to_low_r ? csp_pkg::CSP_PH_LOW : csp_pkg::CSP_PH_IDLE;
					end else begin
						dead_r <= dead_r + 4'h1;
					end
				end
				csp_pkg::CSP_PH_LOW: begin
					if (i_cycle_start || i_undercurrent_comparator || !lowok_r) begin
						ph_r <= csp_pkg::CSP_PH_DEAD;
						dead_r <= '0;
						dead_to_low_r <= 1'b0;
						o_discontinuous_conduction <= i_undercurrent_comparator;
					end
				end
				default: ph_r <= csp_pkg::CSP_PH_IDLE;
			endcase
		end
	end
	// drives decoded from phase; low side held off while light load
	assign o_high_side_switch = (ph_r == csp_pkg::CSP_PH_HIGH);
	assign o_low_side_switch = (ph_r == csp_pkg::CSP_PH_LOW) && lowok_r;
	chk_never_both: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!(o_high_side_switch && o_low_side_switch))
		else $error("both switches on");
	chk_dead_gap: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$fell(o_high_side_switch) |-> !o_low_side_switch [*2])
		else $error("no dead time after high side");
	chk_uc_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_low_side_switch && i_undercurrent_comparator && i_run) |=> !o_low_side_switch)
		else $error("low side stayed on under undercurrent");
	cov_full_cycle: cover property (@(posedge i_clk) disable iff (!i_rst_b)
		o_high_side_switch ##[1:20] o_low_side_switch);
endmodule : csp_pwm
`default_nettype wire

// ### testbench/csp_cpu_model.sv
// processor side model: throttles while the hot line is low, logs each pulse width
`timescale 1ns/1ps
`default_nettype none
module csp_cpu_model (
	// clock
	input wire logic i_clk,
	// throttle request from the supervisor
	input wire logic i_processor_hot_n,
	// last low width in cycles and pulse count
	output var int o_width,
	output var int o_pulses
);
	// two-state counters start at zero, so no separate initial driver
	int run_r;
	// width is logged at release so an extended pulse reports its full length
	always @(posedge i_clk) begin
		if (i_processor_hot_n === 1'b0) begin
			run_r <= run_r + 1;
		end else if (run_r > 0) begin
			o_width <= run_r;
			o_pulses <= o_pulses + 1;
			run_r <= 0;
		end
	end
endmodule : csp_cpu_model
`default_nettype wire

// ### testbench/charger_supervisor_processor_hot_n_wdt_tb.sv
// self-checking bench for the charger supervisor
`timescale 1ns/1ps
`default_nettype none
module charger_supervisor_processor_hot_n_wdt_tb;
	localparam int WID [4] = '{30, 10, 50, 80};
	localparam int DIV [4] = '{167, 125, 100, 125};
	logic i_clk, i_rst_b, sclr, cset, dep, ag, bp_n, cmp, det, cvw, ccw;
	logic ovc2, ovcd, ov125, ov200, conv, ramp, uc, bl, ah;
	logic [6:0] en, st;
	logic [1:0] hw, wp, fs;
	logic [3:0] lv;
	logic [2:0] cells;
	logic [23:0] dg [4];
	logic hot_n, cal, asw, rsw, bsw, ocl, wx, cs, hs, ls, discontinuous_conduction;
	int bad_count, n_checks, width, pulses, k, t, p0;

	csp_supervisor #(.HOT_W0_CYC(30), .HOT_W1_CYC(10), .HOT_W2_CYC(50), .HOT_W3_CYC(80),
		.WDT_P1_CYC(200), .WDT_P2_CYC(300), .WDT_P3_CYC(400), .OVC_CYC(20)) dut_u (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_hot_enable(en), .i_hot_width(hw),
		.i_dg_peak(dg[0]), .i_dg_avg(dg[1]), .i_dg_dchg(dg[2]), .i_dg_cmp(dg[3]),
		.i_status_clear(sclr),
		.i_peak_over(lv[0]), .i_avg_over_110(lv[1]), .i_dchg_over(lv[2]), .i_system_voltage_event_under(lv[3]),
		.i_cell_count(cells), .i_adapter_good(ag), .i_battery_present_n(bp_n),
		.i_comparator_output(cmp), .i_adapter_detect(det), .i_cal_set(cset),
		.i_battery_depleted(dep), .i_wdt_period(wp), .i_charge_voltage_limit_wr(cvw),
		.i_charge_current_limit_wr(ccw), .i_ovc_2x(ovc2), .i_ovc_disable(ovcd),
		.i_in_over_125(ov125), .i_in_over_200(ov200), .i_freq_sel(fs), .i_conv_enable(conv),
		.i_ramp_above_eao(ramp), .i_undercurrent_comparator(uc), .i_below_low_level(bl),
		.i_above_high_level(ah), .o_processor_hot_n(hot_n), .o_hot_status(st),
		.o_battery_calibration_mode(cal), .o_adapter_switch(asw), .o_reverse_block_switch(rsw),
		.o_battery_switch(bsw), .o_input_overcurrent_latch(ocl), .o_wdt_expired(wx),
		.o_cycle_start(cs), .o_high_side_switch(hs), .o_low_side_switch(ls),
		.o_discontinuous_conduction(discontinuous_conduction));
	csp_cpu_model cpu_u (.i_clk(i_clk), .i_processor_hot_n(hot_n), .o_width(width),
		.o_pulses(pulses));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// converter comparators wander freely; overlap of the switches is never allowed
	always @(posedge i_clk) begin
		{ramp, uc, bl, ah} <= 4'($urandom);
		if (hs === 1'b1 && ls === 1'b1) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, {hs, ls}, 2'h0);
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask : cyc
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_in(input int got, input int lo, input int hi);
		n_checks++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : chk_in
	// toggles the pin of an edge source; the second toggle is the harmless direction
	task automatic flip(input int s);
		if (s == 4) ag <= ~ag;
		else if (s == 5) bp_n <= ~bp_n;
		else cmp <= ~cmp;
	endtask : flip
	task automatic wpulse();
		for (t = 0; t < 400 && pulses == p0; t++) cyc(1);
		// a pulse that never ends is a failure, not a stale width
		if (pulses == p0) bad_count++;
	endtask : wpulse
	// holds the overcurrent inputs n cycles, checks the latch, then releases via detect
	task automatic ovc(input logic [3:0] cfg, input int n, input logic exp);
		cyc(1);
		{ov125, ov200, ovc2, ovcd} <= cfg;
		cyc(n);
		{ov125, ov200} <= 2'h0;
		cyc(3);
		chk({ocl, asw}, {exp, ~exp});
		det <= 1'b0;
		cyc(3);
		chk(ocl, 1'b0);
		det <= 1'b1;
		cyc(4);
	endtask : ovc
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : close_out
	initial begin
		#400000;
		bad_count++;
		close_out();
	end

	initial begin
		{i_rst_b, sclr, cset, dep, cvw, ccw, ovc2, ovcd, ov125, ov200, conv, bp_n} = 12'h0;
		{ag, cmp, det, en, hw, wp, fs, lv, cells} = {3'h7, 7'h0, 2'h2, 2'h0, 2'h1, 4'h0, 3'h3};
		dg = '{24'h3, 24'h3, 24'h3, 24'h3};
		bad_count = 0;
		n_checks = 0;
		k = $urandom(33623);
		cyc(6);
		chk({hot_n, st, cal, bsw, ocl, wx}, {1'b1, 7'h0, 4'b0100});
		i_rst_b <= 1'b1;
		cyc(3);
		chk({asw, rsw}, 2'h3);
		// edge sources with a random width code each
		for (int s = 4; s < 7; s++) begin
			// filter lengths of 2 or more keep the later two-cycle glitch harmless
			for (int j = 0; j < 4; j++) dg[j] <= 24'($urandom % 5 + 2);
			k = $urandom % 4;
			en <= 7'(1 << s);
			hw <= k[1:0];
			sclr <= 1'b1;
			cyc(1);
			sclr <= 1'b0;
			p0 = pulses;
			flip(s);
			cyc(10);
			flip(s);
			wpulse();
			chk_in(width, WID[k], WID[k] + 2);
			chk(st, 32'(1 << s));
		end
		// disabled source must not fire
		en <= 7'h0;
		p0 = pulses;
		flip(6);
		cyc(10);
		flip(6);
		cyc(20);
		chk(pulses, p0);
		// level sources held past the minimum width extend the pulse
		for (int b = 0; b < 4; b++) begin
			for (int j = 0; j < 4; j++) dg[j] <= 24'($urandom % 5 + 2);
			en <= 7'(1 << b);
			hw <= 2'h1;
			sclr <= 1'b1;
			cyc(1);
			sclr <= 1'b0;
			p0 = pulses;
			lv <= 4'(1 << b);
			cyc(30);
			lv <= 4'h0;
			wpulse();
			chk_in(width, 24, 34);
			chk(st, 32'(1 << b));
		end
		// single-cell voltage event and a glitch shorter than the filter
		cells <= 3'h1;
		en <= 7'h09;
		p0 = pulses;
		lv <= 4'h9;
		cyc(2);
		lv <= 4'h8;
		cyc(20);
		lv <= 4'h0;
		en <= 7'h0;
		cyc(10);
		chk(pulses, p0);
		// calibration entry, depletion exit, then removal exit
		cset <= 1'b1;
		cyc(1);
		cset <= 1'b0;
		cyc(3);
		chk({cal, asw, rsw, bsw}, 4'b1001);
		dep <= 1'b1;
		cyc(1);
		dep <= 1'b0;
		cyc(3);
		chk({cal, asw, rsw, bsw}, 4'b0110);
		cset <= 1'b1;
		cyc(1);
		cset <= 1'b0;
		cyc(3);
		bp_n <= 1'b1;
		for (t = 0; t < 12000 && asw !== 1'b1; t++) cyc(1);
		chk_in(t, 0, csp_pkg::BATT_EXIT_CYC);
		chk(cal, 1'b0);
		bp_n <= 1'b0;
		// overcurrent: hold, short hold, disabled, 2x ignoring 1.25x, 2x
		ovc(4'b1000, 30, 1'b1);
		ovc(4'b1000, 12, 1'b0);
		ovc(4'b1001, 30, 1'b0);
		ovc(4'b1010, 30, 1'b0);
		ovc(4'b1110, 30, 1'b1);
		// switching period per frequency code
		conv <= 1'b1;
		for (int f = 0; f < 4; f++) begin
			fs <= 2'(f);
			cyc(3);
			for (t = 0; t < 400 && cs !== 1'b1; t++) cyc(1);
			cyc(1);
			for (t = 1; t < 400 && cs !== 1'b1; t++) cyc(1);
			chk_in(t, DIV[f] - 1, DIV[f] + 1);
		end
		// watchdog expiry, suspension, kicks and disable
		wp <= 2'h1;
		for (t = 0; t < 400 && wx !== 1'b1; t++) cyc(1);
		chk_in(t, 198, 203);
		k = 0;
		repeat (30) begin
			cyc(1);
			if (hs !== 1'b0 || ls !== 1'b0 || discontinuous_conduction !== 1'b0) k++;
		end
		chk(k, 0);
		chk({cal, fs}, 3'h3);
		cvw <= 1'b1;
		cyc(1);
		cvw <= 1'b0;
		cyc(3);
		chk(wx, 1'b0);
		repeat (2) begin
			cyc(150);
			ccw <= 1'b1;
			cyc(1);
			ccw <= 1'b0;
		end
		k = 0;
		repeat (150) begin
			cyc(1);
			if (hs === 1'b1 || wx !== 1'b0) k++;
		end
		chk_in(k, 1, 150);
		chk(wx, 1'b0);
		wp <= 2'h0;
		cyc(500);
		chk(wx, 1'b0);
		close_out();
	end
endmodule : charger_supervisor_processor_hot_n_wdt_tb
`default_nettype wire
